/* File: cpm_pkg.sv */
package cpm_pkg;
	localparam int CPM_NUM_CNT = 4;
	localparam int CPM_NUM_EVT = 28;
	localparam int CPM_SEL_W = 5;
	localparam int CPM_ADDR_W = 3;
	// Register indices within the monitor's slice of control space.
	localparam logic [2:0] CPM_IDX_CTRL = 3'h0;
	localparam logic [2:0] CPM_IDX_CYCLE = 3'h1;
	localparam logic [2:0] CPM_IDX_CNT0 = 3'h2;
	// Control register fields.
	localparam int CPM_BIT_ENABLE = 0;
	localparam int CPM_BIT_CLEAR = 1;
	localparam int CPM_BIT_IDLE = 2;
	localparam int CPM_SEL_LSB0 = 12;
	localparam logic [31:0] CPM_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CPM_CTRL_WMASK = 32'hffff_f001;
	localparam logic [31:0] CPM_CNT_RESET = 32'h0000_0000;
	// Event codes named by their use.
	localparam logic [4:0] CPM_SEL_DCACHE_HIT = 5'h00;
	localparam logic [4:0] CPM_SEL_TAKEN_BRANCH = 5'h0c;
	localparam logic [4:0] CPM_SEL_UNTAKEN_BRANCH = 5'h0d;
	localparam logic [4:0] CPM_SEL_TRAP_COUNT = 5'h0e;
	localparam logic [4:0] CPM_SEL_IRQ_COUNT = 5'h0f;
	localparam logic [4:0] CPM_SEL_BUS_READS = 5'h10;
	localparam logic [4:0] CPM_SEL_BUS_WRITES = 5'h11;
	localparam logic [4:0] CPM_SEL_COMPLETED_OPS = 5'h12;
	localparam logic [4:0] CPM_SEL_EMPTY_BUNDLES = 5'h14;
	localparam logic [4:0] CPM_SEL_LAST_VALID = 5'h1b;
endpackage

/* File: cpm_monitor.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - Each counter counts the event whose 5-bit code its selector holds.
// - Codes 28 to 31 are reserved and never increment a counter.
// - Architectural events are sampled when their bundle commits.
// - User-mode access to any monitor register raises a privilege fault.
// - Control bit 0 enables counting; resets to zero.
// - Writing 1 to bit 1 clears all counters; bit reads as zero.
// - Bit 2 is set on idle entry; software clears it by writing 1.
// - Four 5-bit selectors at bits 16:12 up to 31:27, reset zero.
// - Events in the cycle of a control write are not counted.
// - While counting is enabled the core may not enter idle.
// - A counter gains exactly one per selected event while enabled.
// - A software write to a counter beats a coincident increment.
// - Reads exclude same-cycle events, which are still added afterwards.
// - Cycle counter is read/write 32 bits and wraps silently.
// - Event counters are 32 bits and wrap silently with no flag.
// - Code 12 counts taken branches, code 13 untaken conditionals.
// - Code 14 counts exceptions and debug interrupts, 15 interrupts.
// - Code 18 counts completed ops, excluding inserted nops, long imms.
// - Code 20 counts empty or nop bundles from fetch or interlock stalls.
// - Code 16 counts bus reads, code 17 evictions plus uncached writes.
module cpm_monitor (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset_n,
	// Control space access from the pipeline.
	input wire logic creg_rd,
	input wire logic creg_wr,
	input wire logic [cpm_pkg::CPM_ADDR_W-1:0] creg_idx,
	input wire logic [31:0] creg_wdata,
	input wire logic supervisor,
	output logic [31:0] creg_rdata,
	output logic ctrl_space_privilege_fault,
	// Event pulses, one per bit, already qualified at bundle commit.
	input wire logic [cpm_pkg::CPM_NUM_EVT-1:0] event_pulse,
	// Idle handshake with the core.
	input wire logic idle_request,
	output logic idle_permit,
	output logic idle_entered
);
	import cpm_pkg::*;

	// ************************************************************
	// Access decode.
	// ************************************************************
	logic [31:0] ctrl;
	logic [31:0] cycle_cnt;
	logic [31:0] evt_cnt [CPM_NUM_CNT];
	logic [31:0] next_ctrl;
	logic [31:0] next_cycle_cnt;
	logic [31:0] next_evt_cnt [CPM_NUM_CNT];
	logic [31:0] next_rdata;
	logic next_fault;
	logic next_idle_permit;
	logic next_idle_entered;
	logic acc_ok;
	logic wr_ok;
	logic ctrl_wr;
	logic clear_all;
	logic counting;
	logic idle_now;

	function automatic logic [4:0] sel_of(input logic [31:0] c, input int n);
		sel_of = c[CPM_SEL_LSB0 + n*CPM_SEL_W +: CPM_SEL_W];
	endfunction

	// Events arrive already sampled at commit, so the increment uses them
	// directly in the cycle they are reported.
	function automatic logic hit(input logic [4:0] sel,
			input logic [CPM_NUM_EVT-1:0] ev);
		hit = 1'b0;
		if (sel <= CPM_SEL_LAST_VALID) begin
			hit = ev[sel];
		end
	endfunction

	always_comb begin
		acc_ok = supervisor;
		wr_ok = creg_wr && acc_ok;
		ctrl_wr = wr_ok && (creg_idx == CPM_IDX_CTRL);
		clear_all = ctrl_wr && creg_wdata[CPM_BIT_CLEAR];
		// The bundle that writes control contributes no events.
		counting = ctrl[CPM_BIT_ENABLE] && !ctrl_wr;
		// An idle request in the cycle that sets enable is refused too.
		idle_now = idle_request && !ctrl[CPM_BIT_ENABLE] &&
			!(ctrl_wr && creg_wdata[CPM_BIT_ENABLE]);
		next_fault = (creg_rd || creg_wr) && !acc_ok;
	end

	// ************************************************************
	// Control register.
	// ************************************************************
	always_comb begin
		next_ctrl = ctrl;
		if (ctrl_wr) begin
			next_ctrl = (creg_wdata & CPM_CTRL_WMASK) |
				(ctrl & ~CPM_CTRL_WMASK);
			if (creg_wdata[CPM_BIT_IDLE]) begin
				next_ctrl[CPM_BIT_IDLE] = 1'b0;
			end
		end
		if (idle_now) begin
			next_ctrl[CPM_BIT_IDLE] = 1'b1;
		end
		next_ctrl[CPM_BIT_CLEAR] = 1'b0;
		next_idle_permit = !next_ctrl[CPM_BIT_ENABLE];
		next_idle_entered = idle_now;
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			ctrl <= CPM_CTRL_RESET;
			ctrl_space_privilege_fault <= 1'b0;
			idle_permit <= 1'b1;
			idle_entered <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			ctrl_space_privilege_fault <= next_fault;
			idle_permit <= next_idle_permit;
			idle_entered <= next_idle_entered;
		end
	end

	// ************************************************************
	// Cycle counter.
	// ************************************************************
	always_comb begin
		next_cycle_cnt = cycle_cnt;
		if (counting) begin
			next_cycle_cnt = cycle_cnt + 32'h0000_0001;
		end
		if (wr_ok && creg_idx == CPM_IDX_CYCLE) begin
			next_cycle_cnt = creg_wdata;
		end
		if (clear_all) begin
			next_cycle_cnt = CPM_CNT_RESET;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			cycle_cnt <= CPM_CNT_RESET;
		end else begin
			cycle_cnt <= next_cycle_cnt;
		end
	end

	// ************************************************************
	// Event counters.
	// ************************************************************
	for (genvar g = 0; g < CPM_NUM_CNT; g++) begin : g_cnt
		always_comb begin
			next_evt_cnt[g] = evt_cnt[g];
			if (counting && hit(sel_of(ctrl, g), event_pulse)) begin
				// Wraps silently past all ones.
				next_evt_cnt[g] = evt_cnt[g] + 32'h0000_0001;
			end
			if (wr_ok && creg_idx == CPM_IDX_CNT0 + 3'(g)) begin
				next_evt_cnt[g] = creg_wdata;
			end
			if (clear_all) begin
				next_evt_cnt[g] = CPM_CNT_RESET;
			end
		end

		always_ff @(posedge clk_sys) begin
			if (!reset_n) begin
				evt_cnt[g] <= CPM_CNT_RESET;
			end else begin
				evt_cnt[g] <= next_evt_cnt[g];
			end
		end
	end

	// ************************************************************
	// Read path.
	// ************************************************************
	// The read returns the value held before this cycle's events, which
	// land in the counter at the same edge and show on the next read.
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (creg_rd && acc_ok) begin
			case (creg_idx)
				CPM_IDX_CTRL: next_rdata = ctrl;
				CPM_IDX_CYCLE: next_rdata = cycle_cnt;
				CPM_IDX_CNT0: next_rdata = evt_cnt[0];
				CPM_IDX_CNT0 + 3'h1: next_rdata = evt_cnt[1];
				CPM_IDX_CNT0 + 3'h2: next_rdata = evt_cnt[2];
				CPM_IDX_CNT0 + 3'h3: next_rdata = evt_cnt[3];
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			creg_rdata <= 32'h0000_0000;
		end else begin
			creg_rdata <= next_rdata;
		end
	end

	// ************************************************************
	// Checks.
	// ************************************************************
	property p_user_fault;
		@(posedge clk_sys) disable iff (!reset_n)
		(creg_wr && !supervisor) |=> ctrl_space_privilege_fault;
	endproperty
	a_user_fault: assert property (p_user_fault)
		else $error("User access did not fault.");

	property p_user_no_write;
		@(posedge clk_sys) disable iff (!reset_n)
		(creg_wr && !supervisor && creg_idx == CPM_IDX_CYCLE && !ctrl[0])
			|=> $stable(cycle_cnt);
	endproperty
	a_user_no_write: assert property (p_user_no_write)
		else $error("User write changed a register.");

	property p_clear_bit_zero;
		@(posedge clk_sys) disable iff (!reset_n)
		ctrl_wr |=> !ctrl[CPM_BIT_CLEAR];
	endproperty
	a_clear_bit_zero: assert property (p_clear_bit_zero)
		else $error("Clear bit read back as one.");

	property p_clear_all;
		@(posedge clk_sys) disable iff (!reset_n)
		clear_all |=> (cycle_cnt == 32'h0 && evt_cnt[0] == 32'h0);
	endproperty
	a_clear_all: assert property (p_clear_all)
		else $error("Counters not cleared.");

	property p_idle_set;
		@(posedge clk_sys) disable iff (!reset_n)
		(idle_request && !ctrl[0] && !(ctrl_wr && creg_wdata[0]))
			|=> ctrl[CPM_BIT_IDLE];
	endproperty
	a_idle_set: assert property (p_idle_set)
		else $error("Idle flag not set.");

	property p_no_idle_enabled;
		@(posedge clk_sys) disable iff (!reset_n)
		ctrl[CPM_BIT_ENABLE] |-> !idle_permit && !idle_entered;
	endproperty
	a_no_idle_enabled: assert property (p_no_idle_enabled)
		else $error("Idle allowed while counting.");

	property p_ctrl_write_freeze;
		@(posedge clk_sys) disable iff (!reset_n)
		(ctrl_wr && !creg_wdata[CPM_BIT_CLEAR]) |=> $stable(evt_cnt[0]);
	endproperty
	a_ctrl_write_freeze: assert property (p_ctrl_write_freeze)
		else $error("Event counted during control write.");

	property p_cycle_step;
		@(posedge clk_sys) disable iff (!reset_n)
		(counting && !wr_ok) |=> cycle_cnt == $past(cycle_cnt) + 32'h1;
	endproperty
	a_cycle_step: assert property (p_cycle_step)
		else $error("Cycle counter did not step.");

	property p_cycle_hold;
		@(posedge clk_sys) disable iff (!reset_n)
		(!ctrl[0] && !wr_ok) [*2] |=> $stable(cycle_cnt);
	endproperty
	a_cycle_hold: assert property (p_cycle_hold)
		else $error("Cycle counter moved while disabled.");

	property p_reserved_code;
		@(posedge clk_sys) disable iff (!reset_n)
		(sel_of(ctrl, 0) > CPM_SEL_LAST_VALID && !wr_ok)
			|=> $stable(evt_cnt[0]);
	endproperty
	a_reserved_code: assert property (p_reserved_code)
		else $error("Reserved code incremented a counter.");

	property p_write_wins;
		@(posedge clk_sys) disable iff (!reset_n)
		(wr_ok && creg_idx == CPM_IDX_CNT0) |=> evt_cnt[0] == $past(creg_wdata);
	endproperty
	a_write_wins: assert property (p_write_wins)
		else $error("Counter write lost to increment.");

	property p_user_read_fault;
		@(posedge clk_sys) disable iff (!reset_n)
		(creg_rd && !supervisor) |=>
			ctrl_space_privilege_fault && creg_rdata == 32'h0000_0000;
	endproperty
	a_user_read_fault: assert property (p_user_read_fault)
		else $error("User read did not fault or returned data.");

	property p_event_step;
		@(posedge clk_sys) disable iff (!reset_n)
		(counting && hit(sel_of(ctrl, 1), event_pulse) && !wr_ok)
			|=> evt_cnt[1] == $past(evt_cnt[1]) + 32'h0000_0001;
	endproperty
	a_event_step: assert property (p_event_step)
		else $error("Counter one did not gain one.");

	property p_read_before_events;
		@(posedge clk_sys) disable iff (!reset_n)
		(creg_rd && supervisor && creg_idx == CPM_IDX_CNT0)
			|=> creg_rdata == $past(evt_cnt[0]);
	endproperty
	a_read_before_events: assert property (p_read_before_events)
		else $error("Read included same-cycle events.");
endmodule

/* File: cpm_event_source.sv */
`timescale 1ns/100ps
module cpm_event_source (
	// Request from the bench.
	input wire logic fire,
	input wire logic [4:0] code,
	// Commit-qualified event lines.
	output logic [cpm_pkg::CPM_NUM_EVT-1:0] event_pulse
);
	import cpm_pkg::*;
	// A reserved code makes every line fire at once, a worst-case burst.
	always_comb begin
		event_pulse = '0;
		if (fire && code < 5'(CPM_NUM_EVT)) begin
			event_pulse[code] = 1'b1;
		end else if (fire) begin
			event_pulse = '1;
		end
	end
endmodule

/* File: core_performance_monitor_bench.sv */
`timescale 1ns/100ps
module core_performance_monitor_bench;
	import cpm_pkg::*;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic creg_rd = 1'b0;
	logic creg_wr = 1'b0;
	logic [2:0] creg_idx = 3'h0;
	logic [31:0] creg_wdata = 32'h0;
	logic supervisor = 1'b1;
	logic [31:0] creg_rdata;
	logic fault;
	logic [CPM_NUM_EVT-1:0] event_pulse;
	logic idle_request = 1'b0;
	logic idle_permit;
	logic idle_entered;
	logic fire = 1'b0;
	logic [4:0] code = 5'h0;
	logic [31:0] rd;
	logic flt;
	int err_total = 0;
	int n_compared = 0;
	always #5 clk_sys = ~clk_sys;
	cpm_monitor DUT (.clk_sys(clk_sys), .reset_n(reset_n),
		.creg_rd(creg_rd), .creg_wr(creg_wr), .creg_idx(creg_idx),
		.creg_wdata(creg_wdata), .supervisor(supervisor),
		.creg_rdata(creg_rdata), .ctrl_space_privilege_fault(fault),
		.event_pulse(event_pulse), .idle_request(idle_request),
		.idle_permit(idle_permit), .idle_entered(idle_entered));
	cpm_event_source src (.fire(fire), .code(code),
		.event_pulse(event_pulse));
	task automatic chk(input string nm, input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One access; its answer is sampled in the following cycle.
	task automatic acc(input logic w, input logic [2:0] i,
		input logic [31:0] d, input logic ev);
		creg_rd = ~w;
		creg_wr = w;
		creg_idx = i;
		creg_wdata = d;
		fire = ev;
		@(posedge clk_sys);
		#1;
		rd = creg_rdata;
		flt = fault;
	endtask
	task automatic quiet(input logic ev);
		creg_rd = 1'b0;
		creg_wr = 1'b0;
		fire = ev;
		@(posedge clk_sys);
		#1;
	endtask
	function automatic logic [31:0] sel4(input int c);
		logic [4:0] s;
		s = 5'(c);
		return {s, s, s, s, 12'h003};
	endfunction
	task automatic t_codes;
		logic [31:0] ex;
		for (int c = 0; c < 32; c++) begin
			code = 5'(c);
			acc(1'b1, 3'h0, sel4(c), 1'b0);
			quiet(1'b1);
			// Stop by clearing only enable, keeping the selectors.
			acc(1'b1, 3'h0, sel4(c) & 32'hffff_fffc, 1'b0);
			for (int i = 0; i < 4; i++) begin
				acc(1'b0, 3'(i + 2), 32'h0, 1'b0);
				ex = (c < CPM_NUM_EVT) ? 32'h0000_0001 : 32'h0000_0000;
				chk("event_counter_n", rd, ex);
			end
		end
		acc(1'b0, 3'h0, 32'h0, 1'b0);
		chk("monitor_control", rd, 32'hffff_f000);
		quiet(1'b0);
	endtask
	// Distinct selectors; counter k sees its own code k+1 times.
	task automatic t_sel(input logic [4:0] s0, s1, s2, s3);
		logic [4:0] s [4];
		s = '{s0, s1, s2, s3};
		acc(1'b1, 3'h0, {s3, s2, s1, s0, 12'h003}, 1'b0);
		for (int k = 0; k < 4; k++) begin
			code = s[k];
			repeat (k + 1) begin
				quiet(1'b1);
			end
		end
		acc(1'b1, 3'h0, {s3, s2, s1, s0, 12'h000}, 1'b0);
		for (int k = 0; k < 4; k++) begin
			acc(1'b0, 3'(k + 2), 32'h0, 1'b0);
			chk("event_counter_n", rd, 32'(k + 1));
		end
		quiet(1'b0);
	endtask
	task automatic t_same;
		code = 5'h0;
		acc(1'b1, 3'h0, 32'h3, 1'b0);
		acc(1'b1, 3'h0, 32'h1, 1'b1);
		acc(1'b0, 3'h2, 32'h0, 1'b1);
		chk("event_counter_n", rd, 32'h0);
		acc(1'b0, 3'h2, 32'h0, 1'b0);
		chk("event_counter_n", rd, 32'h1);
		acc(1'b1, 3'h2, 32'h5, 1'b1);
		acc(1'b0, 3'h2, 32'h0, 1'b0);
		chk("event_counter_n", rd, 32'h5);
		acc(1'b1, 3'h2, 32'hffff_ffff, 1'b0);
		acc(1'b0, 3'h2, 32'h0, 1'b1);
		acc(1'b0, 3'h2, 32'h0, 1'b0);
		chk("event_counter_n", rd, 32'h0);
		acc(1'b1, 3'h0, 32'h0, 1'b0);
		acc(1'b1, 3'h1, 32'hffff_fffe, 1'b0);
		acc(1'b0, 3'h1, 32'h0, 1'b0);
		acc(1'b0, 3'h1, 32'h0, 1'b0);
		chk("core_cycle_counter", rd, 32'hffff_fffe);
		acc(1'b1, 3'h0, 32'h1, 1'b0);
		acc(1'b0, 3'h1, 32'h0, 1'b0);
		chk("core_cycle_counter", rd, 32'hffff_fffe);
		acc(1'b0, 3'h1, 32'h0, 1'b0);
		chk("core_cycle_counter", rd, 32'hffff_ffff);
		acc(1'b0, 3'h1, 32'h0, 1'b0);
		chk("core_cycle_counter", rd, 32'h0);
		acc(1'b1, 3'h0, 32'h0, 1'b0);
		quiet(1'b0);
	endtask
	task automatic t_fault_idle;
		acc(1'b1, 3'h1, 32'h0000_0007, 1'b0);
		supervisor = 1'b0;
		acc(1'b1, 3'h0, 32'h1, 1'b0);
		chk("fault", {31'h0, flt}, 32'h1);
		acc(1'b1, 3'h1, 32'h0000_0055, 1'b0);
		chk("fault", {31'h0, flt}, 32'h1);
		acc(1'b0, 3'h1, 32'h0, 1'b0);
		chk("fault", {31'h0, flt}, 32'h1);
		chk("core_cycle_counter", rd, 32'h0);
		supervisor = 1'b1;
		acc(1'b0, 3'h0, 32'h0, 1'b0);
		chk("monitor_control", rd, 32'h0);
		chk("fault", {31'h0, flt}, 32'h0);
		acc(1'b0, 3'h1, 32'h0, 1'b0);
		chk("core_cycle_counter", rd, 32'h0000_0007);
		idle_request = 1'b1;
		quiet(1'b0);
		chk("idle_entered", {31'h0, idle_entered}, 32'h1);
		idle_request = 1'b0;
		acc(1'b1, 3'h0, 32'h0, 1'b0);
		acc(1'b0, 3'h0, 32'h0, 1'b0);
		chk("monitor_control", rd, 32'h4);
		idle_request = 1'b1;
		acc(1'b1, 3'h0, 32'h5, 1'b0);
		chk("idle_entered", {31'h0, idle_entered}, 32'h0);
		acc(1'b0, 3'h0, 32'h0, 1'b0);
		chk("monitor_control", rd, 32'h1);
		idle_request = 1'b1;
		quiet(1'b0);
		chk("idle_entered", {31'h0, idle_entered}, 32'h0);
		chk("idle_permit", {31'h0, idle_permit}, 32'h0);
		idle_request = 1'b0;
		acc(1'b1, 3'h0, 32'h0, 1'b0);
		quiet(1'b0);
	endtask
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		#1;
		reset_n = 1'b1;
		chk("idle_permit", {31'h0, idle_permit}, 32'h1);
		acc(1'b0, 3'h0, 32'h0, 1'b0);
		chk("monitor_control", rd, 32'h0);
		t_codes();
		t_sel(CPM_SEL_TAKEN_BRANCH, CPM_SEL_UNTAKEN_BRANCH, CPM_SEL_TRAP_COUNT,
			CPM_SEL_IRQ_COUNT);
		t_sel(CPM_SEL_BUS_READS, CPM_SEL_BUS_WRITES, CPM_SEL_COMPLETED_OPS,
			CPM_SEL_EMPTY_BUNDLES);
		t_same();
		t_fault_idle();
		results();
	end
endmodule
